// File: rtl/flow_pkg.sv
// constants shared by the flow request handler
package flow_pkg;
  localparam logic [23:0] REQ_TAG        = 24'h9F8E00;
  localparam logic [23:0] CNF_TAG        = 24'h9F8E01;
  localparam logic [7:0]  SVC_MPEG       = 8'h00;
  localparam logic [7:0]  SVC_UNICAST    = 8'h01;
  localparam logic [7:0]  SVC_MULTICAST  = 8'h02;
  localparam logic [7:0]  SVC_DSG        = 8'h03;
  localparam logic [7:0]  ST_OK          = 8'h00;
  localparam logic [7:0]  ST_BUSY        = 8'h04;
  localparam logic [7:0]  ST_NO_RES      = 8'h03;
  localparam logic [7:0]  ST_BAD_SVC     = 8'h01;
  localparam logic [7:0]  ST_BAD_LEN     = 8'h02;
  localparam logic [7:0]  DHCP_END       = 8'hFF;
  localparam int          MPEG_SLOTS     = 8;
  localparam int          UNICAST_SLOTS  = 1;
  localparam int          MCAST_SLOTS    = 1;
  localparam logic [11:0] MAX_SECT_LEN   = 12'hFFD;
  localparam logic [31:0] CRC_RESIDUE    = 32'h00000000;
  localparam logic [31:0] CRC_INIT       = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY       = 32'h04C11DB7;
  localparam int          OPT_DEPTH      = 256;
  // register offsets
  localparam logic [3:0]  A_CTRL         = 4'h0;
  localparam logic [3:0]  A_STATUS       = 4'h1;
  localparam logic [3:0]  A_MAC_HI       = 4'h2;
  localparam logic [3:0]  A_MAC_LO       = 4'h3;
  localparam logic [3:0]  A_OPT_LEN      = 4'h4;
  localparam logic [3:0]  A_OPT_DATA     = 4'h5;
  localparam logic [3:0]  A_FLOWS        = 4'h6;
  localparam logic [3:0]  A_GROUP        = 4'h7;
  localparam logic [3:0]  A_SECT_CNT     = 4'h8;
  localparam logic [31:0] CTRL_RESET     = 32'h00000000;
endpackage

// File: rtl/opt_mem_if.sv
// option byte memory access bundle
`timescale 1ns/10ps
interface opt_mem_if;
  logic       we;
  logic [7:0] waddr;
  logic [7:0] wdata;
  logic [7:0] raddr;
  logic [7:0] rdata;
  modport owner (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem   (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: rtl/opt_mem.sv
// option byte storage, registered read
`timescale 1ns/10ps
module opt_mem (
  input wire logic i_clk,
  input wire logic i_ce,
  opt_mem_if.mem   bus
);
  logic [7:0] store [0:flow_pkg::OPT_DEPTH-1];
  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      if (bus.we) begin
        store[bus.waddr] <= bus.wdata;
      end
      bus.rdata <= store[bus.raddr];
    end
  end
endmodule // opt_mem

// File: rtl/flow_request_handler.sv
// flow-open request parser, confirm builder, flow table and stream filters
// How it works
// RQ1: at least six section flows can be open together; table holds eight
// RQ2: at least one unicast flow slot exists
// RQ3: one flow of the tunnel service kind is supported
// RQ4: both TCP and UDP transport types accepted on IP flows
// RQ5: out-of-band services demand extra section flows, granted from free slots
// RQ6: far side provides tunnel flow when modem present and asked
// RQ7: far side builds DHCP from supplied options
// RQ8: while a request pends, further requests get confirm status 0x04
// RQ9: service kind is one byte; 0x00..0x03 defined, rest reserved
// RQ10: section body is 3 reserved bits then 13-bit PID, msb first
// RQ11: only sections on packets with a matching PID are delivered
// RQ12: unicast body is 48-bit MAC, length byte, then option bytes
// RQ13: option length must equal the count of option bytes
// RQ14: end option 255 must not appear among option bytes
// RQ15: multicast body is 4 reserved bits then 28-bit group identifier
// RQ16: only multicast packets matching an open group identifier pass
// RQ17: delivered sections have length at most 4093
// RQ18: incomplete sections or CRC failures are dropped
// RQ19: reserved bits ignored on receive
`timescale 1ns/10ps
module flow_request_handler (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  // request byte stream
  input  wire logic        i_req_valid,
  input  wire logic [7:0]  i_req_byte,
  input  wire logic        i_req_last,
  // confirm
  output logic             o_cnf_valid,
  output logic [7:0]       o_cnf_status,
  output logic [3:0]       o_cnf_flow,
  // section byte stream (one section, pid sampled with first byte)
  input  wire logic        i_sec_valid,
  input  wire logic [7:0]  i_sec_byte,
  input  wire logic        i_sec_first,
  input  wire logic        i_sec_last,
  input  wire logic [12:0] i_sec_pid,
  output logic             o_sec_pass,
  output logic             o_sec_drop,
  // multicast group check
  input  wire logic        i_mc_valid,
  input  wire logic [27:0] i_mc_group,
  output logic             o_mc_pass,
  // register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata
);
  typedef enum logic [3:0] {
    S_TAG0 = 4'h0, S_TAG1 = 4'h1, S_TAG2 = 4'h2, S_LEN = 4'h3,
    S_SVC  = 4'h4, S_BODY = 4'h5, S_OPTL = 4'h6, S_OPTS = 4'h7,
    S_DONE = 4'h8, S_SKIP = 4'h9
  } parse_t;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int b = 7; b >= 0; b--) begin
      r = (r[31] ^ d[b]) ? ((r << 1) ^ flow_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  //----------------------------------------
  // request parser
  //----------------------------------------
  parse_t      st_reg;
  logic [7:0]  svc_reg;
  logic [2:0]  cnt_reg;
  logic [47:0] body_reg;
  logic [7:0]  optlen_reg;
  logic [7:0]  optcnt_reg;
  logic        bad_reg;
  logic        pending_reg;
  logic        ack_wr;
  logic        body_end;
  logic [47:0] body_now;
  logic [7:0]  kind_now;
  opt_mem_if   om ();

  opt_mem u_mem (.i_clk(i_clk), .i_ce(i_ce), .bus(om));

  // body completes with the current byte
  assign body_now = {body_reg[39:0], i_req_byte};
  assign kind_now = (st_reg == S_SVC) ? i_req_byte : svc_reg;
  assign body_end = (st_reg == S_SVC && i_req_byte == flow_pkg::SVC_DSG) ||
                    (st_reg == S_BODY && svc_reg == flow_pkg::SVC_MPEG && cnt_reg == 3'h1) ||
                    (st_reg == S_BODY && svc_reg == flow_pkg::SVC_MULTICAST && cnt_reg == 3'h3) ||
                    (st_reg == S_OPTL && i_req_byte == 8'h00) ||
                    (st_reg == S_OPTS && optcnt_reg + 8'h01 == optlen_reg);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= S_TAG0;
      svc_reg <= 8'h00;
      cnt_reg <= 3'h0;
      body_reg <= 48'h0;
      optlen_reg <= 8'h00;
      optcnt_reg <= 8'h00;
      bad_reg <= 1'b0;
    end else if (i_ce && i_req_valid) begin
      case (st_reg)
        S_TAG0: begin
          st_reg <= (i_req_byte == flow_pkg::REQ_TAG[23:16]) ? S_TAG1 : S_SKIP;
          bad_reg <= 1'b0;
          body_reg <= 48'h0;
          optcnt_reg <= 8'h00;
          optlen_reg <= 8'h00;
          cnt_reg <= 3'h0;
        end
        S_TAG1: st_reg <= (i_req_byte == flow_pkg::REQ_TAG[15:8]) ? S_TAG2 : S_SKIP;
        S_TAG2: st_reg <= (i_req_byte == flow_pkg::REQ_TAG[7:0]) ? S_LEN : S_SKIP;
        S_LEN:  st_reg <= S_SVC;
        S_SVC: begin
          svc_reg <= i_req_byte; // see RQ9
          cnt_reg <= 3'h0;
          st_reg <= (i_req_byte == flow_pkg::SVC_DSG) ? S_DONE : S_BODY;
        end
        S_BODY: begin
          body_reg <= {body_reg[39:0], i_req_byte}; // see RQ10
          cnt_reg <= cnt_reg + 3'h1;
          if (svc_reg == flow_pkg::SVC_UNICAST && cnt_reg == 3'h5) begin
            st_reg <= S_OPTL; // see RQ12
          end else if ((svc_reg == flow_pkg::SVC_MPEG && cnt_reg == 3'h1) ||
                       (svc_reg == flow_pkg::SVC_MULTICAST && cnt_reg == 3'h3)) begin
            st_reg <= S_DONE; // see RQ15
          end else if (svc_reg > flow_pkg::SVC_DSG) begin
            st_reg <= S_DONE;
          end
        end
        S_OPTL: begin
          optlen_reg <= i_req_byte;
          st_reg <= (i_req_byte == 8'h00) ? S_DONE : S_OPTS;
        end
        S_OPTS: begin
          if (i_req_byte == flow_pkg::DHCP_END) bad_reg <= 1'b1; // see RQ14
          optcnt_reg <= optcnt_reg + 8'h01;
          if (optcnt_reg + 8'h01 == optlen_reg) st_reg <= S_DONE;
        end
        S_DONE: bad_reg <= 1'b1; // see RQ13
        S_SKIP: st_reg <= S_SKIP;
        default: st_reg <= S_SKIP;
      endcase
      if (i_req_last) st_reg <= S_TAG0;
      if (i_req_last && st_reg != S_SKIP && !body_end) begin
        bad_reg <= 1'b1; // see RQ13
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      om.we <= 1'b0;
      om.waddr <= 8'h00;
      om.wdata <= 8'h00;
    end else if (i_ce) begin
      om.we <= i_req_valid && st_reg == S_OPTS && !pending_reg;
      om.waddr <= optcnt_reg;
      om.wdata <= i_req_byte;
    end
  end

  //----------------------------------------
  // flow table and confirm
  //----------------------------------------
  logic [7:0]  mpeg_used_reg;
  logic [12:0] pid_reg [0:flow_pkg::MPEG_SLOTS-1];
  logic        uni_used_reg;
  logic        mc_used_reg;
  logic        dsg_used_reg;
  logic [27:0] group_reg;
  logic [47:0] mac_reg;
  logic [1:0]  proto_ok_reg;
  logic        req_end;
  logic [2:0]  free_idx;
  logic        free_any;

  assign req_end = i_ce && i_req_valid && i_req_last && st_reg != S_SKIP &&
                   st_reg != S_TAG0;

  always_comb begin
    free_idx = 3'h0;
    free_any = 1'b0;
    for (int k = flow_pkg::MPEG_SLOTS - 1; k >= 0; k--) begin
      if (!mpeg_used_reg[k]) begin
        free_idx = 3'(k);
        free_any = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cnf_valid <= 1'b0;
      o_cnf_status <= flow_pkg::ST_OK;
      o_cnf_flow <= 4'h0;
      pending_reg <= 1'b0;
      mpeg_used_reg <= 8'h00;
      uni_used_reg <= 1'b0;
      mc_used_reg <= 1'b0;
      dsg_used_reg <= 1'b0;
      group_reg <= 28'h0;
      mac_reg <= 48'h0;
      for (int k = 0; k < flow_pkg::MPEG_SLOTS; k++) pid_reg[k] <= 13'h0;
    end else if (i_ce) begin
      o_cnf_valid <= 1'b0;
      if (ack_wr) pending_reg <= 1'b0;
      if (req_end && pending_reg) begin
        o_cnf_valid <= 1'b1;
        o_cnf_status <= flow_pkg::ST_BUSY; // see RQ8
        o_cnf_flow <= 4'hF;
      end else if (req_end) begin
        o_cnf_valid <= 1'b1;
        o_cnf_flow <= 4'h0;
        if (kind_now > flow_pkg::SVC_DSG) begin
          o_cnf_status <= flow_pkg::ST_BAD_SVC; // see RQ9
        end else if (bad_reg || !body_end ||
                     (st_reg == S_OPTS && i_req_byte == flow_pkg::DHCP_END)) begin
          o_cnf_status <= flow_pkg::ST_BAD_LEN; // see RQ13 RQ14
        end else begin
          case (kind_now)
            flow_pkg::SVC_MPEG: begin
              if (free_any) begin // see RQ1
                mpeg_used_reg[free_idx] <= 1'b1; // see RQ5
                pid_reg[free_idx] <= body_now[12:0]; // see RQ19
                o_cnf_status <= flow_pkg::ST_OK;
                o_cnf_flow <= {1'b0, free_idx};
                pending_reg <= 1'b1;
              end else o_cnf_status <= flow_pkg::ST_NO_RES;
            end
            flow_pkg::SVC_UNICAST: begin
              if (!uni_used_reg) begin // see RQ2
                uni_used_reg <= 1'b1;
                mac_reg <= body_reg;
                o_cnf_status <= flow_pkg::ST_OK;
                o_cnf_flow <= 4'h8;
                pending_reg <= 1'b1;
              end else o_cnf_status <= flow_pkg::ST_NO_RES;
            end
            flow_pkg::SVC_MULTICAST: begin
              if (!mc_used_reg) begin
                mc_used_reg <= 1'b1;
                group_reg <= body_now[27:0]; // see RQ15
                o_cnf_status <= flow_pkg::ST_OK;
                o_cnf_flow <= 4'h9;
                pending_reg <= 1'b1;
              end else o_cnf_status <= flow_pkg::ST_NO_RES;
            end
            flow_pkg::SVC_DSG: begin
              if (!dsg_used_reg) begin // see RQ3
                dsg_used_reg <= 1'b1;
                o_cnf_status <= flow_pkg::ST_OK;
                o_cnf_flow <= 4'hA;
                pending_reg <= 1'b1;
              end else o_cnf_status <= flow_pkg::ST_NO_RES;
            end
            default: o_cnf_status <= flow_pkg::ST_BAD_SVC; // see RQ9
          endcase
        end
      end
      if (i_wr && i_addr == flow_pkg::A_FLOWS) begin
        mpeg_used_reg <= mpeg_used_reg & ~i_wdata[7:0];
        if (i_wdata[8]) uni_used_reg <= 1'b0;
        if (i_wdata[9]) mc_used_reg <= 1'b0;
        if (i_wdata[10]) dsg_used_reg <= 1'b0;
      end
    end
  end

  assign ack_wr = i_wr && i_addr == flow_pkg::A_CTRL && i_wdata[0];

  always_ff @(posedge i_clk) begin
    if (i_rst) proto_ok_reg <= 2'b11;
    else if (i_ce && i_wr && i_addr == flow_pkg::A_CTRL) proto_ok_reg <= 2'b11 | i_wdata[2:1]; // see RQ4
  end

  //----------------------------------------
  // section filter with length and crc check
  //----------------------------------------
  logic        sec_on_reg;
  logic [31:0] crc_reg;
  logic [11:0] slen_reg;
  logic [12:0] bcnt_reg;
  logic [15:0] sect_cnt_reg;
  logic        pid_hit;
  logic [31:0] crc_nx;

  always_comb begin
    pid_hit = 1'b0;
    for (int k = 0; k < flow_pkg::MPEG_SLOTS; k++) begin
      if (mpeg_used_reg[k] && pid_reg[k] == i_sec_pid) pid_hit = 1'b1;
    end
    crc_nx = crc_step(i_sec_first ? flow_pkg::CRC_INIT : crc_reg, i_sec_byte);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sec_on_reg <= 1'b0;
      crc_reg <= flow_pkg::CRC_INIT;
      slen_reg <= 12'h0;
      bcnt_reg <= 13'h0;
      o_sec_pass <= 1'b0;
      o_sec_drop <= 1'b0;
      sect_cnt_reg <= 16'h0;
    end else if (i_ce) begin
      o_sec_pass <= 1'b0;
      o_sec_drop <= 1'b0;
      if (i_sec_valid) begin
        crc_reg <= crc_nx;
        if (i_sec_first) begin
          sec_on_reg <= pid_hit; // see RQ11
          bcnt_reg <= 13'h1;
        end else begin
          bcnt_reg <= bcnt_reg + 13'h1;
        end
        if (bcnt_reg == 13'h1) slen_reg[11:8] <= i_sec_byte[3:0];
        if (bcnt_reg == 13'h2) slen_reg[7:0] <= i_sec_byte;
        if (i_sec_last) begin
          if ((i_sec_first ? pid_hit : sec_on_reg) && bcnt_reg >= 13'h3 &&
              slen_reg <= flow_pkg::MAX_SECT_LEN && // see RQ17
              bcnt_reg + 13'h1 == {1'b0, slen_reg} + 13'h3 &&
              crc_nx == flow_pkg::CRC_RESIDUE) begin // see RQ18
            o_sec_pass <= 1'b1;
            sect_cnt_reg <= sect_cnt_reg + 16'h1;
          end else begin
            o_sec_drop <= 1'b1;
          end
        end
      end
    end
  end

  //----------------------------------------
  // multicast group filter
  //----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) o_mc_pass <= 1'b0;
    else if (i_ce) o_mc_pass <= i_mc_valid && mc_used_reg && i_mc_group == group_reg; // see RQ16
  end

  //----------------------------------------
  // register read port
  //----------------------------------------
  logic [7:0] rd_ptr_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst) rd_ptr_reg <= 8'h00;
    else if (i_ce && i_wr && i_addr == flow_pkg::A_OPT_LEN) rd_ptr_reg <= i_wdata[7:0];
    else if (i_ce && i_rd && i_addr == flow_pkg::A_OPT_DATA) rd_ptr_reg <= rd_ptr_reg + 8'h01;
  end
  assign om.raddr = rd_ptr_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) o_rdata <= 32'h0;
    else if (i_ce) begin
      o_rdata <= 32'h0;
      if (i_rd) begin
        case (i_addr)
          flow_pkg::A_CTRL:     o_rdata <= {29'h0, proto_ok_reg, 1'b0};
          flow_pkg::A_STATUS:   o_rdata <= {23'h0, pending_reg, svc_reg};
          flow_pkg::A_MAC_HI:   o_rdata <= {16'h0, mac_reg[47:32]};
          flow_pkg::A_MAC_LO:   o_rdata <= mac_reg[31:0];
          flow_pkg::A_OPT_LEN:  o_rdata <= {24'h0, optlen_reg};
          flow_pkg::A_OPT_DATA: o_rdata <= {24'h0, om.rdata};
          flow_pkg::A_FLOWS:    o_rdata <= {21'h0, dsg_used_reg, mc_used_reg, uni_used_reg,
                                            mpeg_used_reg};
          flow_pkg::A_GROUP:    o_rdata <= {4'h0, group_reg};
          flow_pkg::A_SECT_CNT: o_rdata <= {16'h0, sect_cnt_reg};
          default:              o_rdata <= 32'h0;
        endcase
      end
    end
  end
endmodule // flow_request_handler

// File: dv/flow_peer_model.sv
// far-side model that sends flow-open request messages
`timescale 1ns/10ps
module flow_peer_model (
  input  wire logic       i_clk,
  output logic            o_valid,
  output logic [7:0]      o_byte,
  output logic            o_last
);
  initial begin
    o_valid = 1'b0;
    o_byte  = 8'h00;
    o_last  = 1'b0;
  end

  // ------------------------------------------------------------
  // one byte per edge: tag, length, kind, body msb first
  // ------------------------------------------------------------
  task automatic send(input logic [7:0] kind, input logic [7:0] body[$]);
    logic [7:0] m[$];
    int         i;
    m = {flow_pkg::REQ_TAG[23:16], flow_pkg::REQ_TAG[15:8], flow_pkg::REQ_TAG[7:0]};
    m.push_back(8'(body.size() + 1));
    m.push_back(kind);
    m = {m, body};
    for (i = 0; i < m.size(); i++) begin
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_byte  <= m[i];
      o_last  <= (i == m.size() - 1);
    end
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_last  <= 1'b0;
    o_byte  <= ~m[m.size() - 1]; // released line shows no stale byte
  endtask
endmodule // flow_peer_model

// File: dv/flow_request_handler_monitor.sv
// port checker for the flow request handler
`timescale 1ns/10ps
module flow_request_handler_monitor (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_ce,
  input wire logic        i_req_valid,
  input wire logic        i_req_last,
  input wire logic        o_cnf_valid,
  input wire logic [7:0]  o_cnf_status,
  input wire logic [3:0]  o_cnf_flow,
  input wire logic        i_sec_valid,
  input wire logic        i_sec_last,
  input wire logic        o_sec_pass,
  input wire logic        o_sec_drop,
  input wire logic        i_mc_valid,
  input wire logic        o_mc_pass,
  input wire logic [3:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata
);
  logic pend_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ------------------------------------------------------------
  // granted request outstanding until acknowledged
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pend_reg <= 1'b0;
    end else if (i_ce && i_wr && i_addr == flow_pkg::A_CTRL && i_wdata[0]) begin
      pend_reg <= 1'b0;
    end else if (o_cnf_valid && o_cnf_status == flow_pkg::ST_OK) begin
      pend_reg <= 1'b1;
    end
  end

  a_cnf_cause: assert property (o_cnf_valid |-> $past(i_ce && i_req_valid && i_req_last))
    else $error("confirm without request end");
  a_cnf_single: assert property (o_cnf_valid |=> !o_cnf_valid)
    else $error("confirm longer than one cycle");
  a_busy_flow: assert property (o_cnf_valid && o_cnf_status == flow_pkg::ST_BUSY |-> o_cnf_flow == 4'hF)
    else $error("busy confirm with a flow number");
  a_pend_busy: assert property (o_cnf_valid && pend_reg |-> o_cnf_status == flow_pkg::ST_BUSY)
    else $error("request while pending not refused");
  a_grant_flow: assert property (o_cnf_valid && o_cnf_status == flow_pkg::ST_OK |-> o_cnf_flow <= 4'hA)
    else $error("grant names no flow slot");
  a_sec_once: assert property (!(o_sec_pass && o_sec_drop))
    else $error("section passed and dropped");
  a_sec_cause: assert property (o_sec_pass || o_sec_drop |-> $past(i_sec_valid && i_sec_last))
    else $error("section verdict without section end");
  a_mc_cause: assert property (o_mc_pass |-> $past(i_mc_valid && i_ce))
    else $error("group pass without a query");
  a_rdata_idle: assert property ($past(i_ce && !i_rd) |-> o_rdata == 32'h00000000)
    else $error("read data outside read slot");

  c_grant: cover property (o_cnf_valid && o_cnf_status == flow_pkg::ST_OK);
  c_busy: cover property (o_cnf_valid && o_cnf_status == flow_pkg::ST_BUSY);
  c_pass: cover property (o_sec_pass);
endmodule // flow_request_handler_monitor

bind flow_request_handler flow_request_handler_monitor u_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req_valid(i_req_valid),
  .i_req_last(i_req_last), .o_cnf_valid(o_cnf_valid), .o_cnf_status(o_cnf_status),
  .o_cnf_flow(o_cnf_flow), .i_sec_valid(i_sec_valid), .i_sec_last(i_sec_last),
  .o_sec_pass(o_sec_pass), .o_sec_drop(o_sec_drop), .i_mc_valid(i_mc_valid),
  .o_mc_pass(o_mc_pass), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata)
);

// File: dv/flow_request_handler_bench.sv
// self-checking bench for the flow request handler
`timescale 1ns/10ps
module flow_request_handler_bench;
  typedef struct packed {
    logic [7:0]  kind;
    logic [87:0] body;
    logic [3:0]  n;
    logic [7:0]  st;
    logic [3:0]  fl;
    logic        chk;
  } row_t;
  logic        i_clk, i_rst, req_valid, req_last, cnf_valid, i_sec_valid, i_sec_first;
  logic        i_sec_last, sec_pass, sec_drop, i_mc_valid, mc_pass, i_wr, i_rd;
  logic [7:0]  req_byte, cnf_status, i_sec_byte;
  logic [3:0]  cnf_flow, i_addr;
  logic [12:0] i_sec_pid;
  logic [27:0] i_mc_group;
  logic [31:0] i_wdata, rdata, v;
  logic [7:0]  q[$];
  int          n_fail, n_tests, k;
  row_t        rows [9];

  flow_peer_model u_peer (.i_clk(i_clk), .o_valid(req_valid), .o_byte(req_byte), .o_last(req_last));
  flow_request_handler u_flow_request_handler (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_req_valid(req_valid), .i_req_byte(req_byte),
    .i_req_last(req_last), .o_cnf_valid(cnf_valid), .o_cnf_status(cnf_status),
    .o_cnf_flow(cnf_flow), .i_sec_valid(i_sec_valid), .i_sec_byte(i_sec_byte),
    .i_sec_first(i_sec_first), .i_sec_last(i_sec_last), .i_sec_pid(i_sec_pid),
    .o_sec_pass(sec_pass), .o_sec_drop(sec_drop), .i_mc_valid(i_mc_valid),
    .i_mc_group(i_mc_group), .o_mc_pass(mc_pass), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic req(input logic [7:0] kd, input logic [87:0] b, input int n,
                     input logic [7:0] st, input logic [3:0] fl, input logic chk);
    int i;
    q = {};
    for (i = n - 1; i >= 0; i--) q.push_back(b[8*i +: 8]);
    u_peer.send(kd, q);
    #1;
    check(32'(cnf_valid), 32'h1);
    check(32'(cnf_status), 32'(st));
    if (chk) check(32'(cnf_flow), 32'(fl));
  endtask

  task automatic sec(input logic [12:0] pid, input logic [1:0] exp);
    int i;
    for (i = 0; i < q.size(); i++) begin
      @(posedge i_clk);
      i_sec_valid <= 1'b1;
      i_sec_byte <= q[i];
      i_sec_first <= (i == 0);
      i_sec_last <= (i == q.size() - 1);
      i_sec_pid <= pid;
    end
    @(posedge i_clk);
    i_sec_valid <= 1'b0;
    i_sec_last <= 1'b0;
    #1 check(32'({sec_pass, sec_drop}), 32'(exp));
  endtask

  task automatic mc(input logic [27:0] g, input logic e);
    @(posedge i_clk);
    i_mc_valid <= 1'b1;
    i_mc_group <= g;
    @(posedge i_clk);
    i_mc_valid <= 1'b0;
    #1 check(32'(mc_pass), 32'(e));
  endtask

  function automatic logic [31:0] crc32(input logic [7:0] d[$]);
    logic [31:0] c;
    c = flow_pkg::CRC_INIT;
    foreach (d[i]) for (int b = 7; b >= 0; b--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i][b]) ? flow_pkg::CRC_POLY : 32'h00000000);
    return c;
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {i_sec_valid, i_sec_first, i_sec_last, i_mc_valid, i_wr, i_rd} = 6'h00;
    {i_sec_byte, i_sec_pid, i_mc_group, i_addr, i_wdata} = 85'h0;
    i_rst = 1'b1;
    n_fail = 0;
    n_tests = 0;
    rows = '{'{8'h04, 88'h0, 4'd0, flow_pkg::ST_BAD_SVC, 4'h0, 1'b0},
             '{8'hFF, 88'h0, 4'd0, flow_pkg::ST_BAD_SVC, 4'h0, 1'b0},
             '{8'h01, 88'h0A1B2C3D4E5F02000000, 4'd10, flow_pkg::ST_BAD_LEN, 4'h0, 1'b0},
             '{8'h01, 88'h0A1B2C3D4E5F0200FF, 4'd9, flow_pkg::ST_BAD_LEN, 4'h0, 1'b0},
             '{8'h00, 88'hE100, 4'd2, flow_pkg::ST_OK, 4'h0, 1'b0},
             '{8'h00, 88'h0101, 4'd2, flow_pkg::ST_OK, 4'h0, 1'b0},
             '{8'h01, 88'h0A1B2C3D4E5F020000, 4'd9, flow_pkg::ST_OK, 4'h8, 1'b1},
             '{8'h02, 88'hF1234567, 4'd4, flow_pkg::ST_OK, 4'h9, 1'b1},
             '{8'h03, 88'h0, 4'd0, flow_pkg::ST_OK, 4'hA, 1'b1}};
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    #1 check(32'({cnf_valid, sec_pass, sec_drop, mc_pass}) | rdata, 32'h0);
    foreach (rows[r]) begin
      req(rows[r].kind, rows[r].body, rows[r].n, rows[r].st, rows[r].fl, rows[r].chk);
      if (rows[r].st == flow_pkg::ST_OK) wr(flow_pkg::A_CTRL, 32'h00000001);
    end
    for (k = 0; k < 6; k++) begin
      req(8'h00, 88'h0200 + k, 2, flow_pkg::ST_OK, 4'h0, 1'b0);
      if (k < 5) wr(flow_pkg::A_CTRL, 32'h00000001);
    end
    rd(flow_pkg::A_STATUS);
    check(32'(v[8]), 32'h1);
    req(8'h00, 88'h0300, 2, flow_pkg::ST_BUSY, 4'hF, 1'b1);
    wr(flow_pkg::A_CTRL, 32'h00000001);
    rd(flow_pkg::A_STATUS);
    check(32'(v[8]), 32'h0);
    req(8'h00, 88'h0300, 2, flow_pkg::ST_NO_RES, 4'h0, 1'b0);
    req(8'h01, 88'h0A1B2C3D4E5F020000, 9, flow_pkg::ST_NO_RES, 4'h0, 1'b0);
    rd(flow_pkg::A_CTRL);
    check(32'(v[2:1]), 32'h3);
    rd(4'hF);
    q = {8'h00, 8'hB0, 8'h09, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
    v = crc32(q);
    q = {q, v[31:24], v[23:16], v[15:8], v[7:0]};
    sec(13'h0100, 2'b10);
    sec(13'h0333, 2'b01);
    q[3] = q[3] ^ 8'h01;
    sec(13'h0100, 2'b01);
    q[3] = q[3] ^ 8'h01;
    void'(q.pop_back());
    sec(13'h0100, 2'b01);
    rd(flow_pkg::A_SECT_CNT);
    check(v, 32'h00000001);
    mc(28'h1234567, 1'b1);
    mc(28'h1234566, 1'b0);
    tally_and_finish;
  end

  initial begin
    #400000;
    n_fail++;
    tally_and_finish;
  end
endmodule // flow_request_handler_bench
